// [irv_consts.svh]
`ifndef IRV_CONSTS_SVH
`define IRV_CONSTS_SVH
// register word offsets on the avalon slave
`define IRV_OFF_STATUS    4'h0
`define IRV_OFF_MASK      4'h1
`define IRV_OFF_ENABLE    4'h2
`define IRV_OFF_ELEVATE   4'h3
`define IRV_OFF_CONTROL   4'h4
`define IRV_OFF_VECTOR    4'h5
`define IRV_OFF_RSTCAUSE  4'h6
// reset values
`define IRV_RST_ENABLE    11'h000
`define IRV_RST_MASK      11'h000
`define IRV_RST_ELEVATE   8'hf2
`define IRV_RST_CONTROL   1'h1
// control field positions
`define IRV_CTL_IBIT      0
// vector table, maskable sources
`define IRV_VEC_T1_PAOV   16'hffac
`define IRV_VEC_T1_PAEDGE 16'hffaa
`define IRV_VEC_T2_CH4    16'hffa6
`define IRV_VEC_T2_CH5    16'hffa4
`define IRV_VEC_T2_CH6    16'hffa2
`define IRV_VEC_T2_CH7    16'hffa0
`define IRV_VEC_T2_PAOV   16'hff9c
`define IRV_VEC_T2_PAEDGE 16'hff9a
`define IRV_VEC_GEN_A     16'hff98
`define IRV_VEC_GEN_B     16'hff96
`define IRV_VEC_GEN_C     16'hff94
// reset vectors and priorities
`define IRV_VEC_RST_MAIN  16'hfffe
`define IRV_VEC_RST_CLK   16'hfffc
`define IRV_VEC_RST_WDOG  16'hfffa
`define IRV_PRI_RST_MAIN  2'h1
`define IRV_PRI_RST_CLK   2'h2
`define IRV_PRI_RST_WDOG  2'h3
`endif

// [irv_cpu_model.sv]
`timescale 1ns/100ps
// cpu side: takes a vector only when the bench allows, after a random stall
module irv_cpu_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // bench permission and vector handshake
  input  wire logic ack_en,
  input  wire logic vec_valid,
  output logic      vec_ack
);
  int unsigned wait_cnt; // stall cycles left
  // one-cycle ack pulse, then a fresh random stall of 0..2 cycles
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      vec_ack  <= 1'b0;
      wait_cnt <= 0;
    end else if (vec_ack) begin
      vec_ack  <= 1'b0;
      wait_cnt <= $urandom_range(2, 0);
    end else if (vec_valid && ack_en) begin
      if (wait_cnt == 0) begin
        vec_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule

// [irv_pkg.sv]
package irv_pkg;
  // number of maskable sources handled here
  localparam int IRV_NSRC = 11;
  // one avalon request
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } irv_req_t;
  // one cpu vector fetch result
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } irv_vec_t;
  // reset cause
  typedef enum logic [1:0] {
    IRV_RC_NONE = 2'b00,
    IRV_RC_MAIN = 2'b01,
    IRV_RC_CLK  = 2'b10,
    IRV_RC_WDOG = 2'b11
  } irv_rcause_t;
endpackage

// [irv_src_gate.sv]
`timescale 1ns/100ps
`include "irv_consts.svh"
// one maskable source: local enable, i-bit mask, elevation match
module irv_src_gate import irv_pkg::*; #(
  parameter logic [15:0] VEC = 16'h0000
) (
  // source inputs
  input  wire logic       request,
  input  wire logic       local_en,
  input  wire logic       ibit,
  input  wire logic [7:0] elevate,
  // results
  output logic            active,
  output logic            elevated
);
  // gated by local enable and cleared i-bit
  assign active   = request & local_en & ~ibit;
  // elevation value is the vector low byte
  assign elevated = active & (elevate == VEC[7:0]);
endmodule

// [irv_vector_map.sv]
`timescale 1ns/100ps
`include "irv_consts.svh"
// Contract
// RULE1 - timer1 accumulator overflow to ffac, elev ac
// RULE2 - timer1 accumulator edge to ffaa, elev aa
// RULE3 - timer2 channels 4..7 to ffa6..ffa0
// RULE4 - timer2 accumulator overflow to ff9c
// RULE5 - timer2 accumulator edge to ff9a
// RULE6 - generator reloads a,b,c to ff98,96,94
// RULE7 - elevation value equals vector low byte
// RULE8 - resets fetch from the same table
// RULE9 - reset priorities 1,2,3 with fffe,fffc,fffa
// RULE10 - any reset forces defined start values
// RULE11 - ram contents untouched by reset
// RULE12 - unelevated ties go to higher vector
module irv_vector_map import irv_pkg::*; #(
  parameter int NSRC = IRV_NSRC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // peripheral request lines, bit 0 = ffac ... bit 10 = ff94
  input  wire logic [10:0] src_req,
  // system reset sources, level, sampled
  input  wire logic        por_rst,
  input  wire logic        pin_rst,
  input  wire logic        lvr_rst,
  input  wire logic        clkmon_rst,
  input  wire logic        wdog_rst,
  // cpu vector fetch
  input  wire logic        vec_ack,
  output logic             vec_valid,
  output logic [15:0]      vec_addr,
  output logic             sys_rst,
  // interrupt out
  output logic             irq
);
  // elaboration check: table, masks and registers are sized for eleven sources
  if (NSRC != 11) begin : gen_bad_nsrc
    $error("irv_vector_map supports exactly 11 sources");
  end

  // vector table for the maskable sources, index 0 highest address
  localparam logic [15:0] VTAB [0:10] = '{
    `IRV_VEC_T1_PAOV,  // RULE1
    `IRV_VEC_T1_PAEDGE, // RULE2
    `IRV_VEC_T2_CH4, `IRV_VEC_T2_CH5, `IRV_VEC_T2_CH6, `IRV_VEC_T2_CH7, // RULE3
    `IRV_VEC_T2_PAOV,  // RULE4
    `IRV_VEC_T2_PAEDGE, // RULE5
    `IRV_VEC_GEN_A, `IRV_VEC_GEN_B, `IRV_VEC_GEN_C // RULE6
  };

  // software registers
  logic [10:0]      local_en;   // local interrupt enables
  logic [7:0]       elevate;    // priority elevation value
  logic             ibit;       // cpu i-bit mirror
  logic [10:0]      status;     // sticky pending bits
  logic [10:0]      mask;       // unmask bits for irq
  irv_rcause_t      rcause;     // last reset cause
  // gating results
  logic [10:0]      active;
  logic [10:0]      elev_hit;
  irv_req_t         req;

  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata};

  // per source gating, one instance each
  genvar g;
  generate
    for (g = 0; g < 11; g++) begin : gen_src
      irv_src_gate #(.VEC(VTAB[g])) u_gate (
        .request  (src_req[g]),
        .local_en (local_en[g]),
        .ibit     (ibit),
        .elevate  (elevate),
        .active   (active[g]),
        .elevated (elev_hit[g])
      );
    end
  endgenerate

  // reset arbitration, lowest priority number wins
  wire rst_main = por_rst | pin_rst | lvr_rst;
  wire rst_any  = rst_main | clkmon_rst | wdog_rst;
  wire [15:0] rst_vec = rst_main   ? `IRV_VEC_RST_MAIN :  // RULE9
                        clkmon_rst ? `IRV_VEC_RST_CLK  :  // RULE9
                                     `IRV_VEC_RST_WDOG;   // RULE9
  wire irv_rcause_t rst_cause = rst_main   ? IRV_RC_MAIN :
                                clkmon_rst ? IRV_RC_CLK  : IRV_RC_WDOG;

  // pick elevated source, else highest vector address
  logic [3:0] pick;
  logic       pick_ok;
  always_comb begin
    pick    = 4'h0;
    pick_ok = 1'b0;
    for (int i = 10; i >= 0; i--) begin
      if (active[i]) begin
        pick    = 4'(i);  // RULE12
        pick_ok = 1'b1;
      end
    end
    for (int i = 0; i < 11; i++) begin
      if (elev_hit[i]) begin
        pick    = 4'(i);  // RULE7
        pick_ok = 1'b1;
      end
    end
  end

  // resets and interrupts share one fetch path
  wire irv_vec_t next_vec = rst_any ? irv_vec_t'{valid: 1'b1, addr: rst_vec} :  // RULE8
                            pick_ok ? irv_vec_t'{valid: 1'b1, addr: VTAB[pick]} :
                                      irv_vec_t'{valid: 1'b0, addr: 16'h0000};

  // bus decode
  wire wr_en   = req.write & ~avs_waitrequest;
  // read data are captured when the request is first seen, so they stand with waitrequest low
  wire rd_en   = req.read  & avs_waitrequest;
  wire wr_stat = wr_en & (req.address == `IRV_OFF_STATUS);
  wire wr_mask = wr_en & (req.address == `IRV_OFF_MASK);
  wire wr_en_r = wr_en & (req.address == `IRV_OFF_ENABLE);
  wire wr_elev = wr_en & (req.address == `IRV_OFF_ELEVATE);
  wire wr_ctl  = wr_en & (req.address == `IRV_OFF_CONTROL);
  // next sticky and mask values for the interrupt line; only stat_keep is shared with the status register
  wire [10:0] stat_clr    = wr_stat ? req.writedata[10:0] : 11'h000;
  wire [10:0] stat_keep   = (status & ~stat_clr) | active;  // set wins over clear
  wire [10:0] next_status = rst_any ? 11'h000 : stat_keep;
  wire [10:0] next_mask   = rst_any ? `IRV_RST_MASK :
                            wr_mask ? req.writedata[10:0] : mask;
  logic [31:0] rd_mux;
  always_comb begin
    unique case (req.address)
      `IRV_OFF_STATUS:   rd_mux = {21'h0, status};
      `IRV_OFF_MASK:     rd_mux = {21'h0, mask};
      `IRV_OFF_ENABLE:   rd_mux = {21'h0, local_en};
      `IRV_OFF_ELEVATE:  rd_mux = {24'h0, elevate};
      `IRV_OFF_CONTROL:  rd_mux = {31'h0, ibit};
      `IRV_OFF_VECTOR:   rd_mux = {15'h0, vec_valid, vec_addr};
      `IRV_OFF_RSTCAUSE: rd_mux = {30'h0, rcause};
      default:           rd_mux = 32'h0;
    endcase
  end

  // waitrequest: one wait cycle per access, then accept
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= ~((req.read | req.write) & avs_waitrequest);
      if (rd_en) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // control registers, all to start values on any reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      local_en <= `IRV_RST_ENABLE;   // RULE10
      mask     <= `IRV_RST_MASK;     // RULE10
      elevate  <= `IRV_RST_ELEVATE;  // RULE10
      ibit     <= `IRV_RST_CONTROL;  // RULE10
    end else if (rst_any) begin
      local_en <= `IRV_RST_ENABLE;   // RULE10
      mask     <= `IRV_RST_MASK;
      elevate  <= `IRV_RST_ELEVATE;
      ibit     <= `IRV_RST_CONTROL;
    end else begin
      if (wr_en_r) local_en <= req.writedata[10:0];
      if (wr_mask) mask     <= req.writedata[10:0];
      if (wr_elev) elevate  <= req.writedata[7:0];
      if (wr_ctl)  ibit     <= req.writedata[`IRV_CTL_IBIT];
    end
  end

  // sticky status: set beats write-one-to-clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= 11'h000;
    end else if (rst_any) begin
      status <= 11'h000;  // RULE10
    end else begin
      status <= stat_keep;
    end
  end

  // reset cause loaded with the new cause on each system reset, cleared only by arst_n
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rcause <= IRV_RC_NONE;
    end else if (rst_any) begin
      rcause <= rst_cause;
    end
  end

  // vector output held until the cpu acknowledges or a reset source replaces it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      vec_valid <= 1'b0;
      vec_addr  <= 16'h0000;
      sys_rst   <= 1'b1;
      irq       <= 1'b0;
    end else begin
      sys_rst <= rst_any;
      irq     <= |(next_status & next_mask);
      if (rst_any || !vec_valid || vec_ack) begin
        vec_valid <= next_vec.valid;
        vec_addr  <= next_vec.addr;
      end
    end
  end
  // ram is outside this block and has no reset path here  // RULE11

  // checks
  property p_rst_main;
    @(posedge core_clk) disable iff (!arst_n)
      (por_rst | pin_rst | lvr_rst) |=> (vec_valid && vec_addr == 16'hfffe);
  endproperty
  a_rst_main: assert property (p_rst_main) else $error("main reset vector wrong"); // RULE9
  property p_rst_clk;
    @(posedge core_clk) disable iff (!arst_n)
      (clkmon_rst && !rst_main) |=> (vec_addr == 16'hfffc);
  endproperty
  a_rst_clk: assert property (p_rst_clk) else $error("clock monitor vector wrong"); // RULE9
  property p_rst_wdog;
    @(posedge core_clk) disable iff (!arst_n)
      (wdog_rst && !rst_main && !clkmon_rst) |=> (vec_addr == 16'hfffa);
  endproperty
  a_rst_wdog: assert property (p_rst_wdog) else $error("watchdog vector wrong"); // RULE9
  property p_rst_defaults;
    @(posedge core_clk) disable iff (!arst_n)
      rst_any |=> (local_en == 11'h000 && ibit && elevate == 8'hf2);
  endproperty
  a_rst_defaults: assert property (p_rst_defaults) else $error("reset values lost"); // RULE10
  property p_ibit_blocks;
    @(posedge core_clk) disable iff (!arst_n)
      (ibit && !rst_any && !vec_valid) |=> !vec_valid;
  endproperty
  a_ibit_blocks: assert property (p_ibit_blocks) else $error("masked source fetched"); // RULE1
  property p_t1_paov;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && !vec_valid && active[0] && elev_hit == 11'h0) |=> vec_addr == 16'hffac;
  endproperty
  a_t1_paov: assert property (p_t1_paov) else $error("top source not first"); // RULE12
  property p_gen_c;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && !vec_valid && active == 11'h400) |=> vec_addr == 16'hff94;
  endproperty
  a_gen_c: assert property (p_gen_c) else $error("generator c vector wrong"); // RULE6
  property p_elevate;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && !vec_valid && |elev_hit) |=> vec_addr[7:0] == $past(elevate);
  endproperty
  a_elevate: assert property (p_elevate) else $error("elevated source not first"); // RULE7
  // timer1 edge source alone fetches its own vector
  property p_t1_edge;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && !vec_valid && active == 11'h002) |=> vec_addr == `IRV_VEC_T1_PAEDGE;
  endproperty
  a_t1_edge: assert property (p_t1_edge) else $error("timer1 edge vector wrong"); // RULE2
  // timer2 channel 4 alone fetches the top channel vector
  property p_t2_ch4;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && !vec_valid && active == 11'h004) |=> vec_addr == `IRV_VEC_T2_CH4;
  endproperty
  a_t2_ch4: assert property (p_t2_ch4) else $error("timer2 channel 4 vector wrong"); // RULE3
  // timer2 channel 7 alone fetches the bottom channel vector
  property p_t2_ch7;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && !vec_valid && active == 11'h020) |=> vec_addr == `IRV_VEC_T2_CH7;
  endproperty
  a_t2_ch7: assert property (p_t2_ch7) else $error("timer2 channel 7 vector wrong"); // RULE3
  // timer2 accumulator overflow alone
  property p_t2_paov;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && !vec_valid && active == 11'h040) |=> vec_addr == `IRV_VEC_T2_PAOV;
  endproperty
  a_t2_paov: assert property (p_t2_paov) else $error("timer2 overflow vector wrong"); // RULE4
  // timer2 accumulator edge alone
  property p_t2_paedge;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && !vec_valid && active == 11'h080) |=> vec_addr == `IRV_VEC_T2_PAEDGE;
  endproperty
  a_t2_paedge: assert property (p_t2_paedge) else $error("timer2 edge vector wrong"); // RULE5
  // generator a reload alone
  property p_gen_a;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && !vec_valid && active == 11'h100) |=> vec_addr == `IRV_VEC_GEN_A;
  endproperty
  a_gen_a: assert property (p_gen_a) else $error("generator a vector wrong"); // RULE6
  // generator b reload alone
  property p_gen_b;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && !vec_valid && active == 11'h200) |=> vec_addr == `IRV_VEC_GEN_B;
  endproperty
  a_gen_b: assert property (p_gen_b) else $error("generator b vector wrong"); // RULE6
  // every reset source fetches from the top of the shared table
  property p_rst_table;
    @(posedge core_clk) disable iff (!arst_n)
      rst_any |=> (vec_valid && vec_addr >= `IRV_VEC_RST_WDOG);
  endproperty
  a_rst_table: assert property (p_rst_table) else $error("reset vector outside table"); // RULE8
  // system reset output follows the sources by one cycle
  property p_sys_rst;
    @(posedge core_clk) disable iff (!arst_n)
      1'b1 |=> (sys_rst == $past(rst_any));
  endproperty
  a_sys_rst: assert property (p_sys_rst) else $error("system reset output wrong"); // RULE10
  // reset cause only moves on a reset source
  property p_rcause_keep;
    @(posedge core_clk) disable iff (!arst_n)
      !rst_any |=> $stable(rcause);
  endproperty
  a_rcause_keep: assert property (p_rcause_keep) else $error("reset cause changed"); // RULE9
  // an unacknowledged vector is never replaced by an interrupt
  property p_vec_hold;
    @(posedge core_clk) disable iff (!arst_n)
      (vec_valid && !vec_ack && !rst_any) |=> (vec_valid && $stable(vec_addr));
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("pending vector replaced");
  // interrupt line is high exactly while an unmasked sticky bit is set
  property p_irq_level;
    @(posedge core_clk) disable iff (!arst_n)
      irq == |(status & mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt line wrong");
  // a source event is kept even when cleared in the same cycle
  property p_set_wins;
    @(posedge core_clk) disable iff (!arst_n)
      (!rst_any && |active) |=> ((status & $past(active)) == $past(active));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost");
  // waitrequest drops for one cycle only
  property p_wait_one;
    @(posedge core_clk) disable iff (!arst_n)
      !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
endmodule

// [test_interrupt_reset_vector_map.sv]
`timescale 1ns/100ps
module test_interrupt_reset_vector_map import irv_pkg::*;;
  logic        core_clk, arst_n, avs_read, avs_write, avs_waitrequest, ack_en;
  logic        por_rst, pin_rst, lvr_rst, clkmon_rst, wdog_rst;
  logic        vec_ack, vec_valid, sys_rst, irq;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, m;
  logic [10:0] src_req;
  logic [15:0] vec_addr;
  logic [15:0] exp_q[$]; // expected vectors in fetch order
  logic [15:0] vtab[11] = '{16'hffac, 16'hffaa, 16'hffa6, 16'hffa4, 16'hffa2, 16'hffa0,
                            16'hff9c, 16'hff9a, 16'hff98, 16'hff96, 16'hff94};
  logic [4:0]  rsel[7] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h03, 5'h11};
  logic [15:0] rvec[7] = '{16'hfffe, 16'hfffe, 16'hfffe, 16'hfffc, 16'hfffa, 16'hfffc, 16'hfffe};
  logic [31:0] rcau[7] = '{1, 1, 1, 2, 3, 2, 1};
  int          fail_count, comparisons, taken, i, j;

  // 50 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  irv_vector_map DUT (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .src_req, .por_rst, .pin_rst, .lvr_rst,
    .clkmon_rst, .wdog_rst, .vec_ack, .vec_valid, .vec_addr, .sys_rst, .irq);
  irv_cpu_model cpu (.core_clk, .arst_n, .ack_en, .vec_valid, .vec_ack);

  task automatic complete_run();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      complete_run();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // note the expected vector, retire source k, then let the cpu take it
  task automatic take(input int k, input logic [15:0] v);
    int t0;
    int n;
    exp_q.push_back(v);
    t0 = taken;
    if (k >= 0) begin
      @(posedge core_clk);
      src_req[k] <= 1'b0;
      bus(1, 4'h0, 32'h1 << k);
    end
    @(posedge core_clk);
    ack_en <= 1'b1;
    for (n = 0; n < 40 && taken == t0; n++) @(posedge core_clk);
    ack_en <= 1'b0;
    if (taken == t0) begin
      fail_count++;
      complete_run();
    end
  endtask

  // watcher: every vector the cpu takes is matched with the oldest note
  always @(negedge core_clk) begin
    if (vec_valid === 1'b1 && vec_ack === 1'b1) begin
      taken++;
      if (exp_q.size() == 0) begin
        chk("vec_addr spare", 32'h0, {16'h1, vec_addr});
      end else begin
        chk("vec_addr", {16'h0, exp_q.pop_front()}, {16'h0, vec_addr});
      end
    end
  end

  initial begin
    void'($urandom(32'hc0ecaee9));
    {arst_n, avs_read, avs_write, ack_en, por_rst, pin_rst, lvr_rst, clkmon_rst} = '0;
    {wdog_rst, avs_address, avs_writedata, src_req} = '0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    bus(0, 4'h4, 0);
    chk("control", 32'h1, rd);
    chk("sys_rst idle", 0, sys_rst);
    bus(0, 4'h2, 0);
    chk("enable", 32'h0, rd);
    bus(0, 4'h7, 0);
    chk("unmapped", 32'h0, rd);
    // every reset source, plus clock monitor over watchdog and por over watchdog
    for (i = 0; i < 7; i++) begin
      bus(1, 4'h3, $urandom_range(255, 0));
      @(posedge core_clk);
      {por_rst, pin_rst, lvr_rst, clkmon_rst, wdog_rst} <= rsel[i];
      @(posedge core_clk);
      {por_rst, pin_rst, lvr_rst, clkmon_rst, wdog_rst} <= 5'h0;
      @(negedge core_clk);
      chk("sys_rst", 1, sys_rst);
      take(-1, rvec[i]);
      bus(0, 4'h6, 0);
      chk("reset cause", rcau[i], rd);
      bus(0, 4'h3, 0);
      chk("elevate", 32'hf2, rd);
    end
    m = $urandom;
    bus(1, 4'h1, m);
    bus(0, 4'h1, 0);
    chk("mask", m & 32'h7ff, rd);
    // local enable off, then i-bit set: no vector
    bus(1, 4'h1, 32'h0);
    bus(1, 4'h2, 32'h7fe);
    bus(1, 4'h4, 32'h0);
    src_req[0] <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk("gated valid", 0, vec_valid);
    bus(1, 4'h4, 32'h1);
    bus(1, 4'h2, 32'h7ff);
    repeat (4) @(negedge core_clk);
    chk("ibit valid", 0, vec_valid);
    bus(1, 4'h4, 32'h0);
    repeat (4) @(negedge core_clk);
    chk("masked irq", 0, irq);
    take(0, vtab[0]);
    // each source alone, with its interrupt line
    bus(1, 4'h1, 32'h7ff);
    for (i = 0; i < 11; i++) begin
      src_req[i] <= 1'b1;
      repeat (4) @(negedge core_clk);
      chk("irq", 1, irq);
      bus(0, 4'h0, 0);
      chk("status", 32'h1 << i, rd);
      take(i, vtab[i]);
      chk("irq cleared", 0, irq);
    end
    // random tie without elevation: higher vector first
    i = $urandom_range(9, 0);
    j = $urandom_range(10, i + 1);
    @(posedge core_clk);
    src_req <= 11'h1 << i | 11'h1 << j;
    bus(0, 4'h5, 0);
    chk("vector reg", 32'h10000 | vtab[i], rd);
    take(i, vtab[i]);
    take(j, vtab[j]);
    // elevation lifts the lowest vector above the highest
    bus(1, 4'h3, 32'h94);
    @(posedge core_clk);
    src_req <= 11'h401;
    take(10, 16'hff94);
    take(0, 16'hffac);
    complete_run();
  end
endmodule
